// file: design/amc_regs.sv
`timescale 1ns/100ps
// Functional notes
// - Two-bit power field: 0 normal, 1..3 deeper standby; resets to 3.
// - Black clamp runs only while its enable bit is 1; resets to 1.
// - Settling-speed bit 1 selects fast clamp settling, 0 normal.
// - Fast-recovery bit makes sampler gain updates trigger very fast clamping.
// - During blanking outputs show zero or clamp level per blank-level bit.
// - Restore-bypass 0 enables dc restore during blanking, 1 disables it.
// - Output-disable bit 1 puts data outputs in high impedance.
// - Latch-mode 0 registers on output phase edge; 1 is transparent.
// - Gray-code bit 1 presents pixel words in Gray code.
// - Sampler gain codes 0,4,6,7 only; applied at next frame sync. The code stores any 3-bit code.
// - Ten-bit variable gain code, resets to 0xF, applied at frame sync.
// - Ten-bit clamp target, resets to 0x1EC, applied at frame sync.
// - Divide bit 1 halves reference clock; 0 passes it through.
// - Writing 1 to soft reset restores all registers; bit self-clears.
// - Output-activate 0 holds outputs inactive; 1 enables at frame sync.
// - Reset-pin option turns the sync pin into active-low reset input.
// - Sync enable (default 1) accepts external sync; polarity bit sets level.
// - Suspend bit stops clocks while sync pulse is active.
// - During suspend mask line, frame, vertical clocks per mask bits.
// - Shadow enable plus shadow-write routes shadowed writes to shadow copies.
// - Soft sync bit starts a sync event and self-clears after it.
// - Core reset bit 0 holds timing core in reset; upper bits written 0.
// - Further 28-bit words go to the next higher address.
// - Immediate registers update at bit 27; others at frame sync fall.
module amc_regs #(
  parameter int DATA_W = 12
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset
  input wire logic ce, // Clock enable
  input wire logic serClk, // Serial clock
  input wire logic serData, // Serial data
  input wire logic serLoad_n, // Serial frame, low during write
  input wire logic frameSyncIn, // Frame sync
  input wire logic syncPin, // External sync or reset pin
  input wire logic refClkIn, // Reference clock in
  input wire logic [DATA_W-1:0] pixelIn, // Converted pixel word
  input wire logic pixelBlanking, // Pixel blanking
  input wire logic outPhaseTick, // Output phase rising edge
  output logic [1:0] standbyLevel, // Power level
  output logic blackClampOn, // Clamp running
  output logic clampSettleFast, // Fast settling
  output logic gainChangeFastClamp, // Very fast clamp pulse
  output logic dcRestoreOn, // Dc restore active
  output logic [DATA_W-1:0] pixelOut, // Pixel data
  output logic pixelOutEn, // Pixel output enable
  output logic [amc_pkg::SGAIN_W-1:0] samplerGainCode, // Sampler gain
  output logic [amc_pkg::GAIN_W-1:0] variableGainCode, // Variable gain
  output logic [amc_pkg::GAIN_W-1:0] blackClampTarget, // Clamp target
  output logic refClockOut, // Reference clock out
  output logic extResetReq, // Reset from sync pin
  output logic syncClockHold, // Clocks suspended
  output logic holdMaskLine, // Line sync masked
  output logic holdMaskFrame, // Frame sync masked
  output logic holdMaskVclk, // Vertical clocks masked
  output logic enhancedSyncOn, // Enhanced sync
  output logic syncEvent, // Sync event pulse
  output logic coreReset, // Timing core in reset
  output logic oscillatorReset // Oscillator powered down
);
  typedef struct packed {
    logic [amc_pkg::NREG-1:0][amc_pkg::WORD_W-1:0] regs;
    logic [amc_pkg::NREG-1:0][amc_pkg::WORD_W-1:0] pend;
    logic [amc_pkg::NREG-1:0][amc_pkg::WORD_W-1:0] shad;
    logic [amc_pkg::NREG-1:0] pendV;
    logic [amc_pkg::NREG-1:0] shadV;
    logic [amc_pkg::ADDR_W-1:0] shAddr;
    logic [amc_pkg::WORD_W-1:0] shData;
    logic [5:0] bitCnt;
    logic inData;
    logic sclkQ;
    logic frameQ;
    logic syncQ;
    logic refQ;
    logic [1:0] stby;
    logic clampOn;
    logic settleFast;
    logic fastPulse;
    logic restoreOn;
    logic [DATA_W-1:0] pix;
    logic pixEn;
    logic [amc_pkg::SGAIN_W-1:0] sGain;
    logic [amc_pkg::GAIN_W-1:0] vGain;
    logic [amc_pkg::GAIN_W-1:0] clampTgt;
    logic refOut;
    logic extRst;
    logic hold;
    logic mLine;
    logic mFrame;
    logic mVclk;
    logic enh;
    logic syncEvt;
    logic core;
    logic osc;
  } amc_state_t;

  amc_state_t q;
  amc_state_t d;
  logic sclkRise;
  logic frameFall;
  logic syncAct;
  logic syncStart;
  logic commit;
  logic swRstHit;
  logic active;
  logic [amc_pkg::IDX_W-1:0] idx;
  logic [amc_pkg::WORD_W-1:0] word;
  logic [DATA_W-1:0] pv;

  always_comb begin
    d = q;
    sclkRise = serClk && !q.sclkQ;
    frameFall = !frameSyncIn && q.frameQ;
    syncAct = q.regs[amc_pkg::IDX_SYNC][amc_pkg::B_SYNC_ON]
      && !q.regs[amc_pkg::IDX_RSTPIN][amc_pkg::B_BIT0]
      && (syncPin == q.regs[amc_pkg::IDX_SYNC][amc_pkg::B_SYNC_LVL]);
    syncStart = (syncAct && !q.syncQ) || q.regs[amc_pkg::IDX_SYNC][amc_pkg::B_SOFT_SYNC];
    word = {serData, q.shData[amc_pkg::WORD_W-1:1]};
    idx = q.shAddr[amc_pkg::IDX_W-1:0];
    commit = 1'b0;
    swRstHit = 1'b0;
    d.sclkQ = serClk;
    d.frameQ = frameSyncIn;
    d.syncQ = syncAct;
    d.refQ = refClkIn;
    d.fastPulse = 1'b0;
    // Staged values land together so a field is never half updated
    if (frameFall) begin
      for (int i = 0; i < amc_pkg::NREG; i++) begin
        if (q.pendV[i]) begin
          d.regs[i] = q.pend[i];
          d.pendV[i] = 1'b0;
        end
      end
      d.fastPulse = q.pendV[amc_pkg::IDX_SGAIN]
        && q.regs[amc_pkg::IDX_AFE][amc_pkg::B_GAIN_FAST];
    end
    if (syncStart && q.regs[amc_pkg::IDX_SYNC][amc_pkg::B_SHADOW_ON]) begin
      for (int i = 0; i < amc_pkg::NREG; i++) begin
        if (q.shadV[i]) begin
          d.pend[i] = q.shad[i];
          d.pendV[i] = 1'b1;
          d.shadV[i] = 1'b0;
        end
      end
    end
    if (syncStart) begin
      d.regs[amc_pkg::IDX_SYNC][amc_pkg::B_SOFT_SYNC] = 1'b0;
    end
    // Frame end drops any partial word
    if (serLoad_n) begin
      d.bitCnt = 6'h00;
      d.inData = 1'b0;
    end else if (sclkRise) begin
      if (!q.inData) begin
        d.shAddr = {serData, q.shAddr[amc_pkg::ADDR_W-1:1]};
        d.bitCnt = q.bitCnt + 6'h01;
        if (q.bitCnt == amc_pkg::ADDR_LAST_BIT) begin
          d.inData = 1'b1;
          d.bitCnt = 6'h00;
        end
      end else begin
        d.shData = word;
        d.bitCnt = q.bitCnt + 6'h01;
        if (q.bitCnt == amc_pkg::WORD_LAST_BIT) begin
          commit = 1'b1;
          d.bitCnt = 6'h00;
          d.shAddr = q.shAddr + 12'h001;
        end
      end
    end
    // Writes beyond the map are dropped; the host must avoid them
    if (commit && q.shAddr <= amc_pkg::ADDR_LAST) begin
      if (amc_pkg::VD_TYPE[idx]) begin
        if (q.regs[amc_pkg::IDX_SYNC][amc_pkg::B_SHADOW_ON]
            && q.regs[amc_pkg::IDX_SYNC][amc_pkg::B_SHADOW_WR]) begin
          d.shad[idx] = word & amc_pkg::REG_MASK[idx];
          d.shadV[idx] = 1'b1;
        end else begin
          d.pend[idx] = word & amc_pkg::REG_MASK[idx];
          d.pendV[idx] = 1'b1;
        end
      end else begin
        // Write wins over a same-cycle self-clear
        d.regs[idx] = word & amc_pkg::REG_MASK[idx];
      end
      swRstHit = (idx == amc_pkg::IDX_W'(amc_pkg::IDX_SWRST)) && word[amc_pkg::B_BIT0];
    end
    if (swRstHit) begin
      d.regs = amc_pkg::REG_RST;
      d.pendV = '0;
      d.shadV = '0;
    end
    active = q.regs[amc_pkg::IDX_OUTACT][amc_pkg::B_BIT0];
    d.stby = q.regs[amc_pkg::IDX_AFE][amc_pkg::B_STBY_HI:amc_pkg::B_STBY_LO];
    d.clampOn = q.regs[amc_pkg::IDX_AFE][amc_pkg::B_CLAMP_ON];
    d.settleFast = q.regs[amc_pkg::IDX_AFE][amc_pkg::B_SETTLE_FAST];
    d.restoreOn = pixelBlanking && !q.regs[amc_pkg::IDX_AFE][amc_pkg::B_RESTORE_BYP];
    d.sGain = q.regs[amc_pkg::IDX_SGAIN][amc_pkg::SGAIN_W-1:0];
    d.vGain = q.regs[amc_pkg::IDX_VGAIN][amc_pkg::GAIN_W-1:0];
    d.clampTgt = q.regs[amc_pkg::IDX_CLAMP][amc_pkg::GAIN_W-1:0];
    pv = pixelIn;
    if (pixelBlanking) begin
      pv = q.regs[amc_pkg::IDX_AFE][amc_pkg::B_BLANK_SEL]
        ? {{(DATA_W-amc_pkg::GAIN_W){1'b0}}, d.clampTgt} : '0;
    end
    if (q.regs[amc_pkg::IDX_FMT][amc_pkg::B_GRAY]) begin
      pv = pv ^ (pv >> 1);
    end
    if (!active) begin
      d.pix = '0;
      d.pixEn = 1'b0;
      d.refOut = 1'b0;
    end else begin
      if (q.regs[amc_pkg::IDX_FMT][amc_pkg::B_TRANSP] || outPhaseTick) begin
        d.pix = pv;
      end
      d.pixEn = !q.regs[amc_pkg::IDX_FMT][amc_pkg::B_HIZ];
      if (q.regs[amc_pkg::IDX_CLKDIV][amc_pkg::B_BIT0]) begin
        if (refClkIn && !q.refQ) begin
          d.refOut = !q.refOut;
        end
      end else begin
        d.refOut = refClkIn;
      end
    end
    d.extRst = q.regs[amc_pkg::IDX_RSTPIN][amc_pkg::B_BIT0] && !syncPin;
    d.hold = syncAct && q.regs[amc_pkg::IDX_SYNC][amc_pkg::B_HOLD];
    d.mLine = d.hold && q.regs[amc_pkg::IDX_SYNC][amc_pkg::B_MASK_LINE];
    d.mFrame = d.hold && q.regs[amc_pkg::IDX_SYNC][amc_pkg::B_MASK_FRAME];
    d.mVclk = d.hold && q.regs[amc_pkg::IDX_SYNC][amc_pkg::B_MASK_VCLK];
    d.enh = q.regs[amc_pkg::IDX_SYNC][amc_pkg::B_ENH];
    d.syncEvt = syncStart;
    d.core = !q.regs[amc_pkg::IDX_CORE][amc_pkg::B_BIT0];
    d.osc = !q.regs[amc_pkg::IDX_OSC][amc_pkg::B_BIT0];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
      q.regs <= amc_pkg::REG_RST;
      q.stby <= 2'h3;
      q.clampOn <= 1'b1;
      q.core <= 1'b1;
      q.osc <= 1'b1;
    end else if (ce) begin
      q <= d;
    end
  end

  assign standbyLevel = q.stby;
  assign blackClampOn = q.clampOn;
  assign clampSettleFast = q.settleFast;
  assign gainChangeFastClamp = q.fastPulse;
  assign dcRestoreOn = q.restoreOn;
  assign pixelOut = q.pix;
  assign pixelOutEn = q.pixEn;
  assign samplerGainCode = q.sGain;
  assign variableGainCode = q.vGain;
  assign blackClampTarget = q.clampTgt;
  assign refClockOut = q.refOut;
  assign extResetReq = q.extRst;
  assign syncClockHold = q.hold;
  assign holdMaskLine = q.mLine;
  assign holdMaskFrame = q.mFrame;
  assign holdMaskVclk = q.mVclk;
  assign enhancedSyncOn = q.enh;
  assign syncEvent = q.syncEvt;
  assign coreReset = q.core;
  assign oscillatorReset = q.osc;

  a_soft_reset: assert property (@(posedge clk) disable iff (!rst_n)
    ce && swRstHit |=> q.regs == amc_pkg::REG_RST ##1 (!ce || q.stby == 2'h3))
    else $error("soft reset did not restore defaults");
  a_clamp_gate: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !q.regs[amc_pkg::IDX_AFE][amc_pkg::B_CLAMP_ON] |=> !blackClampOn)
    else $error("clamp running while disabled");
  a_blank_zero: assert property (@(posedge clk) disable iff (!rst_n)
    ce && pixelBlanking && !q.regs[amc_pkg::IDX_AFE][amc_pkg::B_BLANK_SEL]
    && (q.regs[amc_pkg::IDX_FMT][amc_pkg::B_TRANSP] || outPhaseTick) |=> pixelOut == '0)
    else $error("blanked output not zero");
  a_hiz_out: assert property (@(posedge clk) disable iff (!rst_n)
    ce && q.regs[amc_pkg::IDX_FMT][amc_pkg::B_HIZ] |=> !pixelOutEn)
    else $error("outputs driven while disabled");
  a_vd_hold: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !frameFall && !swRstHit |=> $stable(q.regs[amc_pkg::IDX_VGAIN]))
    else $error("frame-type register changed off frame edge");
  a_gray_code: assert property (@(posedge clk) disable iff (!rst_n)
    ce && active && !pixelBlanking && q.regs[amc_pkg::IDX_FMT][amc_pkg::B_GRAY]
    && q.regs[amc_pkg::IDX_FMT][amc_pkg::B_TRANSP] |=> pixelOut == ($past(pixelIn) ^ ($past(pixelIn) >> 1)))
    else $error("pixel word not gray coded");
  a_sync_clear: assert property (@(posedge clk) disable iff (!rst_n)
    ce && q.regs[amc_pkg::IDX_SYNC][amc_pkg::B_SOFT_SYNC] && !commit
    |=> !q.regs[amc_pkg::IDX_SYNC][amc_pkg::B_SOFT_SYNC] && syncEvent)
    else $error("soft sync did not self-clear");
  a_hold_mask: assert property (@(posedge clk) disable iff (!rst_n)
    ce && syncAct && q.regs[amc_pkg::IDX_SYNC][amc_pkg::B_HOLD]
    && q.regs[amc_pkg::IDX_SYNC][amc_pkg::B_MASK_FRAME] |=> syncClockHold && holdMaskFrame)
    else $error("frame mask missing during suspend");
  a_core_held: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !q.regs[amc_pkg::IDX_CORE][amc_pkg::B_BIT0] |=> coreReset)
    else $error("core not held in reset");
  a_out_idle: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !active |=> !pixelOutEn && pixelOut == '0 && !refClockOut)
    else $error("outputs active before activation");
  a_stby_track: assert property (@(posedge clk) disable iff (!rst_n)
    ce |=> standbyLevel == $past(q.regs[amc_pkg::IDX_AFE][amc_pkg::B_STBY_HI:amc_pkg::B_STBY_LO]))
    else $error("standby level not tracking its field");
  a_clamp_run: assert property (@(posedge clk) disable iff (!rst_n)
    ce && q.regs[amc_pkg::IDX_AFE][amc_pkg::B_CLAMP_ON] |=> blackClampOn)
    else $error("clamp stopped while enabled");
  a_settle_track: assert property (@(posedge clk) disable iff (!rst_n)
    ce |=> clampSettleFast == $past(q.regs[amc_pkg::IDX_AFE][amc_pkg::B_SETTLE_FAST]))
    else $error("settling speed not tracking its bit");
  a_fast_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    ce && frameFall && q.pendV[amc_pkg::IDX_SGAIN] && q.regs[amc_pkg::IDX_AFE][amc_pkg::B_GAIN_FAST]
    |=> gainChangeFastClamp)
    else $error("no fast clamp on gain update");
  a_fast_quiet: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !frameFall |=> !gainChangeFastClamp)
    else $error("fast clamp pulse without gain update");
  a_blank_level: assert property (@(posedge clk) disable iff (!rst_n)
    ce && active && pixelBlanking && q.regs[amc_pkg::IDX_AFE][amc_pkg::B_BLANK_SEL]
    && q.regs[amc_pkg::IDX_FMT][amc_pkg::B_GRAY] && q.regs[amc_pkg::IDX_FMT][amc_pkg::B_TRANSP]
    |=> pixelOut == (DATA_W'($past(q.regs[amc_pkg::IDX_CLAMP][amc_pkg::GAIN_W-1:0]))
    ^ (DATA_W'($past(q.regs[amc_pkg::IDX_CLAMP][amc_pkg::GAIN_W-1:0])) >> 1)))
    else $error("blanked output not at clamp level");
  a_restore_on: assert property (@(posedge clk) disable iff (!rst_n)
    ce && pixelBlanking && !q.regs[amc_pkg::IDX_AFE][amc_pkg::B_RESTORE_BYP] |=> dcRestoreOn)
    else $error("dc restore off during blanking");
  a_restore_idle: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !pixelBlanking |=> !dcRestoreOn)
    else $error("dc restore on outside blanking");
  a_hiz_drive: assert property (@(posedge clk) disable iff (!rst_n)
    ce && active && !q.regs[amc_pkg::IDX_FMT][amc_pkg::B_HIZ] |=> pixelOutEn)
    else $error("outputs not driven while enabled");
  a_latch_hold: assert property (@(posedge clk) disable iff (!rst_n)
    ce && active && !q.regs[amc_pkg::IDX_FMT][amc_pkg::B_TRANSP] && !outPhaseTick |=> $stable(pixelOut))
    else $error("registered output moved off phase edge");
  a_sgain_apply: assert property (@(posedge clk) disable iff (!rst_n)
    ce && frameFall && q.pendV[amc_pkg::IDX_SGAIN] && !swRstHit ##1 ce
    |=> samplerGainCode == $past(q.pend[amc_pkg::IDX_SGAIN][amc_pkg::SGAIN_W-1:0], 2))
    else $error("sampler gain not applied at frame edge");
  a_vgain_apply: assert property (@(posedge clk) disable iff (!rst_n)
    ce && frameFall && q.pendV[amc_pkg::IDX_VGAIN] && !swRstHit ##1 ce
    |=> variableGainCode == $past(q.pend[amc_pkg::IDX_VGAIN][amc_pkg::GAIN_W-1:0], 2))
    else $error("variable gain not applied at frame edge");
  a_clamp_apply: assert property (@(posedge clk) disable iff (!rst_n)
    ce && frameFall && q.pendV[amc_pkg::IDX_CLAMP] && !swRstHit ##1 ce
    |=> blackClampTarget == $past(q.pend[amc_pkg::IDX_CLAMP][amc_pkg::GAIN_W-1:0], 2))
    else $error("clamp target not applied at frame edge");
  a_ref_pass: assert property (@(posedge clk) disable iff (!rst_n)
    ce && active && !q.regs[amc_pkg::IDX_CLKDIV][amc_pkg::B_BIT0] |=> refClockOut == $past(refClkIn))
    else $error("reference clock not passed through");
  a_ref_half: assert property (@(posedge clk) disable iff (!rst_n)
    ce && active && q.regs[amc_pkg::IDX_CLKDIV][amc_pkg::B_BIT0] && !(refClkIn && !q.refQ)
    |=> $stable(refClockOut))
    else $error("halved clock moved without input rise");
  a_ext_reset: assert property (@(posedge clk) disable iff (!rst_n)
    ce && q.regs[amc_pkg::IDX_RSTPIN][amc_pkg::B_BIT0] && !syncPin |=> extResetReq)
    else $error("pin reset request missing");
  a_ext_idle: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !q.regs[amc_pkg::IDX_RSTPIN][amc_pkg::B_BIT0] |=> !extResetReq)
    else $error("pin reset request while option off");
  a_pin_not_sync: assert property (@(posedge clk) disable iff (!rst_n)
    ce && q.regs[amc_pkg::IDX_RSTPIN][amc_pkg::B_BIT0] && !q.regs[amc_pkg::IDX_SYNC][amc_pkg::B_SOFT_SYNC]
    |=> !syncEvent)
    else $error("sync event while pin is a reset");
  a_sync_edge: assert property (@(posedge clk) disable iff (!rst_n)
    ce && syncAct && !q.syncQ |=> syncEvent)
    else $error("external sync pulse not taken");
  a_no_hold: assert property (@(posedge clk) disable iff (!rst_n)
    ce && !q.regs[amc_pkg::IDX_SYNC][amc_pkg::B_HOLD]
    |=> !syncClockHold && !holdMaskLine && !holdMaskFrame && !holdMaskVclk)
    else $error("clocks held with suspend off");
  a_line_mask: assert property (@(posedge clk) disable iff (!rst_n)
    ce && syncAct && q.regs[amc_pkg::IDX_SYNC][amc_pkg::B_HOLD]
    && q.regs[amc_pkg::IDX_SYNC][amc_pkg::B_MASK_LINE] |=> holdMaskLine)
    else $error("line mask missing during suspend");
  a_shadow_route: assert property (@(posedge clk) disable iff (!rst_n)
    ce && commit && q.shAddr <= amc_pkg::ADDR_LAST && amc_pkg::VD_TYPE[idx]
    && q.regs[amc_pkg::IDX_SYNC][amc_pkg::B_SHADOW_ON] && q.regs[amc_pkg::IDX_SYNC][amc_pkg::B_SHADOW_WR]
    |=> q.shadV != '0)
    else $error("shadowed write not held in shadow copy");
  a_core_run: assert property (@(posedge clk) disable iff (!rst_n)
    ce && q.regs[amc_pkg::IDX_CORE][amc_pkg::B_BIT0] |=> !coreReset)
    else $error("core held in reset while released");
  a_addr_step: assert property (@(posedge clk) disable iff (!rst_n)
    ce && commit |=> q.shAddr == $past(q.shAddr) + 12'h001)
    else $error("address did not advance after a word");
  a_immediate_write: assert property (@(posedge clk) disable iff (!rst_n)
    ce && commit && q.shAddr == 12'h000
    |=> q.regs[amc_pkg::IDX_AFE] == ($past(word) & amc_pkg::REG_MASK[amc_pkg::IDX_AFE]))
    else $error("immediate register not updated at last bit");
endmodule

// file: design/amc_pkg.sv
package amc_pkg;
  localparam int NREG = 22;
  localparam int ADDR_W = 12;
  localparam int WORD_W = 28;
  localparam int IDX_W = 5;
  localparam logic [ADDR_W-1:0] ADDR_LAST = 12'h015;
  localparam logic [5:0] ADDR_LAST_BIT = 6'h0B;
  localparam logic [5:0] WORD_LAST_BIT = 6'h1B;
  // Register indices (printed offsets)
  localparam int IDX_AFE = 0;
  localparam int IDX_FMT = 1;
  localparam int IDX_SGAIN = 4;
  localparam int IDX_VGAIN = 5;
  localparam int IDX_CLAMP = 6;
  localparam int IDX_CLKDIV = 13;
  localparam int IDX_SWRST = 16;
  localparam int IDX_OUTACT = 17;
  localparam int IDX_RSTPIN = 18;
  localparam int IDX_SYNC = 19;
  localparam int IDX_CORE = 20;
  localparam int IDX_OSC = 21;
  // Field positions
  localparam int B_STBY_LO = 0;
  localparam int B_STBY_HI = 1;
  localparam int B_CLAMP_ON = 2;
  localparam int B_SETTLE_FAST = 3;
  localparam int B_GAIN_FAST = 4;
  localparam int B_BLANK_SEL = 5;
  localparam int B_RESTORE_BYP = 6;
  localparam int B_HIZ = 0;
  localparam int B_TRANSP = 1;
  localparam int B_GRAY = 2;
  localparam int B_BIT0 = 0;
  localparam int B_SYNC_ON = 0;
  localparam int B_SYNC_LVL = 1;
  localparam int B_HOLD = 2;
  localparam int B_ENH = 3;
  localparam int B_MASK_LINE = 4;
  localparam int B_MASK_FRAME = 5;
  localparam int B_MASK_VCLK = 6;
  localparam int B_SHADOW_ON = 7;
  localparam int B_SHADOW_WR = 13;
  localparam int B_SOFT_SYNC = 14;
  localparam int GAIN_W = 10;
  localparam int SGAIN_W = 3;
  // Defaults, index 21 first
  localparam logic [NREG-1:0][WORD_W-1:0] REG_RST = {
    {2{28'h0}}, 28'h0000061, {12{28'h0}}, 28'h00001EC, 28'h000000F,
    28'h0, 28'h00FFFFF, 28'h0, 28'h0000008, 28'h0000007};
  // Stored bits; soft reset bit is never stored, so it reads back as cleared
  localparam logic [NREG-1:0][WORD_W-1:0] REG_MASK = {
    28'h1, 28'h1, 28'h7FFF, 28'h1F, 28'h1, {3{28'h0}}, 28'h1, {6{28'h0}},
    28'h3FF, 28'h3FF, 28'h7, 28'hFFFFFF, 28'h1, 28'hF, 28'h7F};
  // Registers applied at the frame sync falling edge (and shadowed)
  localparam logic [NREG-1:0] VD_TYPE = 22'h022070;
endpackage

// file: verif/amc_host_model.sv
`timescale 1ns/100ps
module amc_host_model (
  input wire logic clk, // System clock
  output logic serClk, // Serial clock
  output logic serData, // Serial data
  output logic serLoad_n // Frame, low while writing
);
  initial begin
    serClk = 1'b0;
    serData = 1'b0;
    serLoad_n = 1'b1;
  end
  task automatic bitOut(input logic b);
    @(negedge clk);
    serClk = 1'b0;
    serData = b;
    @(negedge clk);
    serClk = 1'b1;
  endtask
  // Callers pass defined start addresses (one burst runs on to 0x016), mandated test values, zero upper bits
  task automatic xfer(input logic [11:0] a, input logic [3:0][27:0] w, input int n, input int cut);
    int nb;
    @(negedge clk);
    serLoad_n = 1'b0;
    for (int i = 0; i < 12; i++) bitOut(a[i]);
    for (int k = 0; k < n; k++) begin
      nb = (k == n - 1) ? cut : 28;
      for (int i = 0; i < nb; i++) bitOut(w[k][i]);
    end
    @(negedge clk);
    serClk = 1'b0;
    serData = ~serData; // Released line must not keep its last level
    @(negedge clk);
    serLoad_n = 1'b1;
  endtask
endmodule

// file: verif/amc_regs_bench.sv
`timescale 1ns/100ps
module amc_regs_bench;
  logic clk, rst_n, ce, serClk, serData, serLoad_n, frameSyncIn, syncPin, refClkIn;
  logic pixelBlanking, outPhaseTick, refPrev;
  logic [11:0] pixelIn, pixelOut;
  logic [1:0] standbyLevel;
  logic blackClampOn, clampSettleFast, gainChangeFastClamp, dcRestoreOn, pixelOutEn, refClockOut;
  logic extResetReq, syncClockHold, holdMaskLine, holdMaskFrame, holdMaskVclk, enhancedSyncOn;
  logic syncEvent, coreReset, oscillatorReset;
  logic [2:0] samplerGainCode;
  logic [9:0] variableGainCode, blackClampTarget;
  int miscompares = 0;
  int samples_checked = 0;
  int gainPulses = 0;
  int syncPulses = 0;
  int refRises = 0;
  amc_host_model u_host (.clk, .serClk, .serData, .serLoad_n);
  amc_regs #(.DATA_W(12)) u_amc_regs (.clk, .rst_n, .ce, .serClk, .serData, .serLoad_n, .frameSyncIn,
    .syncPin, .refClkIn, .pixelIn, .pixelBlanking, .outPhaseTick, .standbyLevel, .blackClampOn,
    .clampSettleFast, .gainChangeFastClamp, .dcRestoreOn, .pixelOut, .pixelOutEn, .samplerGainCode,
    .variableGainCode, .blackClampTarget, .refClockOut, .extResetReq, .syncClockHold, .holdMaskLine,
    .holdMaskFrame, .holdMaskVclk, .enhancedSyncOn, .syncEvent, .coreReset, .oscillatorReset);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Pulse outputs last one cycle, so they are counted at every edge
  always @(posedge clk) begin
    if (gainChangeFastClamp === 1'b1) gainPulses++;
    if (syncEvent === 1'b1) syncPulses++;
    if (refClockOut === 1'b1 && refPrev === 1'b0) refRises++;
    refPrev <= refClockOut;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic waitc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [27:0] d);
    u_host.xfer(a, {84'h0, d}, 1, 28);
    waitc(2);
  endtask
  task automatic vdFall();
    frameSyncIn = 1'b1;
    waitc(2);
    frameSyncIn = 1'b0;
    waitc(2);
  endtask
  task automatic refPulses();
    refRises = 0;
    repeat (4) begin
      refClkIn = 1'b1;
      waitc(2);
      refClkIn = 1'b0;
      waitc(2);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    wrap_up();
  end
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    frameSyncIn = 1'b0;
    syncPin = 1'b1;
    refClkIn = 1'b0;
    pixelIn = 12'h000;
    pixelBlanking = 1'b0;
    outPhaseTick = 1'b0;
    waitc(16);
    rst_n = 1'b1;
    waitc(2);
    chk(standbyLevel, 2'h3);
    chk(blackClampOn, 1'b1);
    chk(samplerGainCode, 3'h0);
    chk(variableGainCode, 10'h00F);
    chk(blackClampTarget, 10'h1EC);
    chk(coreReset, 1'b1);
    chk(pixelOutEn, 1'b0);
    chk(holdMaskFrame, 1'b0);
    chk(enhancedSyncOn, 1'b0);
    $display("test defaults done");
    wr(12'h000, 28'h000001A);
    chk(standbyLevel, 2'h2);
    chk(blackClampOn, 1'b0);
    chk(clampSettleFast, 1'b1);
    $display("test immediate done");
    gainPulses = 0;
    u_host.xfer(12'h004, {28'h0, 28'h0000123, 28'h00003FF, 28'h0000006}, 3, 28);
    waitc(2);
    chk(samplerGainCode, 3'h0);
    vdFall();
    chk(samplerGainCode, 3'h6);
    chk(variableGainCode, 10'h3FF);
    chk(blackClampTarget, 10'h123);
    chk(gainPulses, 1);
    u_host.xfer(12'h005, {84'h0, 28'h00002AA}, 1, 10);
    waitc(2);
    vdFall();
    chk(variableGainCode, 10'h3FF);
    $display("test frame update done");
    wr(12'h001, 28'h0000006);
    wr(12'h011, 28'h0000001);
    chk(pixelOutEn, 1'b0);
    vdFall();
    pixelIn = 12'hA5C;
    waitc(3);
    chk(pixelOutEn, 1'b1);
    chk(pixelOut, 12'hA5C ^ (12'hA5C >> 1));
    pixelBlanking = 1'b1;
    waitc(3);
    chk(pixelOut, 12'h000);
    chk(dcRestoreOn, 1'b1);
    wr(12'h000, 28'h000005A);
    chk(dcRestoreOn, 1'b0);
    wr(12'h000, 28'h000007A);
    chk(pixelOut, 12'h123 ^ (12'h123 >> 1));
    pixelBlanking = 1'b0;
    waitc(3);
    wr(12'h001, 28'h0000000);
    pixelIn = 12'h123;
    waitc(3);
    chk(pixelOut, 12'hA5C ^ (12'hA5C >> 1));
    outPhaseTick = 1'b1;
    waitc(1);
    outPhaseTick = 1'b0;
    waitc(2);
    chk(pixelOut, 12'h123);
    wr(12'h001, 28'h0000001);
    chk(pixelOutEn, 1'b0);
    $display("test pixel output done");
    refPulses();
    chk(refRises, 4);
    wr(12'h00D, 28'h0000001);
    vdFall();
    refPulses();
    chk(refRises, 2);
    // Frozen state must ignore reference edges
    ce = 1'b0;
    refPulses();
    chk(refRises, 0);
    ce = 1'b1;
    $display("test clock divide done");
    syncPulses = 0;
    wr(12'h013, 28'h000007D);
    syncPin = 1'b0;
    waitc(4);
    chk(syncPulses, 1);
    chk(syncClockHold, 1'b1);
    chk({holdMaskLine, holdMaskFrame, holdMaskVclk}, 3'h7);
    chk(enhancedSyncOn, 1'b1);
    syncPin = 1'b1;
    waitc(4);
    chk(syncClockHold, 1'b0);
    wr(12'h012, 28'h0000001);
    syncPin = 1'b0;
    waitc(3);
    chk(extResetReq, 1'b1);
    syncPin = 1'b1;
    wr(12'h012, 28'h0000000);
    wr(12'h013, 28'h0004001);
    chk(syncPulses, 2);
    $display("test sync done");
    wr(12'h013, 28'h0002081);
    wr(12'h005, 28'h0000055);
    vdFall();
    chk(variableGainCode, 10'h3FF);
    wr(12'h013, 28'h0004081);
    vdFall();
    chk(variableGainCode, 10'h055);
    $display("test shadow done");
    u_host.xfer(12'h014, {28'h0, 28'h0, 28'h0000001, 28'h0000001}, 3, 28);
    waitc(2);
    chk(coreReset, 1'b0);
    chk(oscillatorReset, 1'b0);
    $display("test core reset done");
    wr(12'h010, 28'h0000001);
    vdFall();
    chk(standbyLevel, 2'h3);
    chk(blackClampOn, 1'b1);
    chk(variableGainCode, 10'h00F);
    chk(blackClampTarget, 10'h1EC);
    chk(coreReset, 1'b1);
    chk(pixelOutEn, 1'b0);
    $display("test soft reset done");
    wrap_up();
  end
endmodule
